//--- logic/masq_device.sv
// Accelerator end: sequences operand ports and computes results
`timescale 1ns/100ps
`include "masq_defs.svh"
module masq_device #(
  parameter int DIV_CLKS   = `MASQ_DIV_CLKS,
  parameter int MUL_CLKS   = `MASQ_MUL_CLKS,
  parameter int SHIFT_CLKS = `MASQ_SHIFT_CLKS
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  masq_if.dev       bus,
  output logic      busy,
  output logic      seqError
);
  initial begin
    if (DIV_CLKS < 1 || DIV_CLKS > `MASQ_DIV_CLKS || MUL_CLKS < 1 ||
        MUL_CLKS > `MASQ_MUL_CLKS || SHIFT_CLKS < 1 || SHIFT_CLKS > `MASQ_SHIFT_CLKS)
      $error("masq_device: latency out of range");
  end

  masq_pkg::masq_state_e state;
  logic [2:0]  aCnt;
  logic [1:0]  bCnt;
  logic [31:0] opnd;
  logic [15:0] opB;
  logic [7:0]  ctrlReg;
  logic [31:0] resA;
  logic [15:0] resB;
  logic [2:0]  aLeft;
  logic [1:0]  bLeft;
  logic [5:0]  lat;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  wire wrA   = bus.acc & bus.wr & (bus.sel == `MASQ_SEL_A);
  wire wrB   = bus.acc & bus.wr & (bus.sel == `MASQ_SEL_B);
  wire wrC   = bus.acc & bus.wr & (bus.sel == `MASQ_SEL_CTRL);
  wire wrS   = bus.acc & bus.wr & (bus.sel == `MASQ_SEL_STAT);
  wire rdA   = bus.acc & ~bus.wr & (bus.sel == `MASQ_SEL_A);
  wire rdB   = bus.acc & ~bus.wr & (bus.sel == `MASQ_SEL_B);
  wire rdC   = bus.acc & ~bus.wr & (bus.sel == `MASQ_SEL_CTRL);
  wire rdS   = bus.acc & ~bus.wr & (bus.sel == `MASQ_SEL_STAT);
  wire clrOp = wrS & ~bus.wdata[`MASQ_BUSY_BIT];
  wire fresh  = (state == masq_pkg::S_IDLE) | (state == masq_pkg::S_READ);
  wire inLoad = (state == masq_pkg::S_LOAD);
  wire inRead = (state == masq_pkg::S_READ);
  wire inErr  = (state == masq_pkg::S_ERROR);

  // Path is told apart by which port was touched first, then by the A byte count and whether B or control follows
  wire mulPath = (bCnt == 2'd2) & (aCnt < 3'd2);
  wire aDivOk  = (bCnt == 2'd0) & (aCnt < 3'd4);
  wire bMulOk  = (aCnt == 3'd0) & (bCnt < 2'd2);
  wire bDivOk  = ((aCnt == 3'd2) | (aCnt == 3'd4)) & (bCnt < 2'd2);
  wire cOk     = (aCnt == 3'd4) & (bCnt == 2'd0);
  wire goodA   = wrA & (fresh | (inLoad & (aDivOk | mulPath)));
  wire goodB   = wrB & (fresh | (inLoad & (bMulOk | bDivOk)));
  wire goodC   = wrC & inLoad & cOk;
  // Writes while busy corrupt too, so a stray write cannot restart a load
  wire badWr   = ~inErr &
                 ((wrA & ~goodA) | (wrB & ~goodB) | (wrC & ~fresh & ~goodC));
  wire launchM = wrA & inLoad & mulPath & (aCnt == 3'd1);
  wire launchD = wrB & inLoad & bDivOk & (bCnt == 2'd1) & (aCnt != 3'd0);
  wire launchS = goodC;
  wire readOkA = inRead & (aLeft != 3'd0);
  wire readOkB = inRead & (aLeft == 3'd0) & (bLeft != 2'd0);
  wire badRd   = ((rdA & ~readOkA) | (rdB & ~readOkB)) & ~fresh & ~inErr;
  wire badRdR  = inRead & ((rdA & ~readOkA) | (rdB & ~readOkB));

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  wire [31:0] dividend = (aCnt == 3'd4) ? opnd : {16'h0000, opnd[15:0]};
  wire [15:0] divisor  = {bus.wdata, opB[7:0]};
  wire        divZero  = (divisor == 16'h0000);
  wire [31:0] divQ     = divZero ? 32'hffffffff : dividend / {16'h0000, divisor};
  wire [31:0] divRw    = divZero ? dividend : dividend % {16'h0000, divisor};
  wire [15:0] mcand    = {bus.wdata, opnd[7:0]};
  wire [31:0] prod     = opB * mcand;
  wire [4:0]  shAmt    = bus.wdata[`MASQ_CNT_MSB:`MASQ_CNT_LSB];
  wire [31:0] shRes    = bus.wdata[`MASQ_LEFT_BIT] ? (opnd << shAmt) : (opnd >> shAmt);
  wire        isNorm   = (bus.wdata == `MASQ_NORM_CODE);
  logic [4:0] lz;

  // Zero input has no leading one; result is then meaningless
  always_comb begin
    lz = 5'd0;
    for (int i = 0; i < 32; i++) begin
      if (opnd[i]) begin
        lz = 5'(31 - i);
      end
    end
  end

  wire [31:0] normRes  = opnd << lz;
  wire [31:0] shOut    = isNorm ? normRes : shRes;

  wire [1:0]  aIdx     = 2'(aLeft - 3'd1);
  wire [7:0]  aByte    = resA[8 * aIdx +: 8];
  wire [7:0]  bByte    = (bLeft == 2'd2) ? resB[15:8] : resB[7:0];
  wire        lastRead = (readOkA & rdA & (aLeft == 3'd1) & (bLeft == 2'd0)) |
                         (readOkB & rdB & (bLeft == 2'd1));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= masq_pkg::S_IDLE;
      aCnt     <= 3'd0;
      bCnt     <= 2'd0;
      opnd     <= 32'h00000000;
      opB      <= 16'h0000;
      ctrlReg  <= `MASQ_CTRL_RST;
      resA     <= 32'h00000000;
      resB     <= 16'h0000;
      aLeft    <= 3'd0;
      bLeft    <= 2'd0;
      lat      <= 6'd0;
      seqError <= 1'b0;
    end else if (clrOp) begin
      state    <= masq_pkg::S_IDLE;
      aCnt     <= 3'd0;
      bCnt     <= 2'd0;
      seqError <= 1'b0;
    end else if (badWr | badRd) begin
      state    <= masq_pkg::S_ERROR;
      seqError <= 1'b1;
    end else if (launchM) begin
      resA  <= prod;
      aLeft <= 3'd4;
      bLeft <= 2'd0;
      lat   <= 6'(MUL_CLKS - 1);
      state <= masq_pkg::S_BUSY;
    end else if (launchD) begin
      resA  <= divQ;
      resB  <= divRw[15:0];
      aLeft <= (aCnt == 3'd4) ? 3'd4 : 3'd2;
      bLeft <= 2'd2;
      lat   <= 6'(DIV_CLKS - 1);
      state <= masq_pkg::S_BUSY;
    end else if (launchS) begin
      resA    <= shOut;
      aLeft   <= 3'd4;
      bLeft   <= 2'd0;
      ctrlReg <= isNorm ? {3'b000, lz} : bus.wdata;
      lat     <= 6'(SHIFT_CLKS - 1);
      state   <= masq_pkg::S_BUSY;
    end else if (goodA) begin
      // A write while idle or reading starts a new load
      aCnt  <= fresh ? 3'd1 : aCnt + 3'd1;
      bCnt  <= fresh ? 2'd0 : bCnt;
      // Multiply reaches A with aCnt zero; old operand bytes must not leak in
      opnd  <= (fresh | (aCnt == 3'd0)) ? {24'h000000, bus.wdata} :
               (opnd | ({24'h000000, bus.wdata} << (8 * 32'(aCnt))));
      state <= masq_pkg::S_LOAD;
    end else if (goodB) begin
      aCnt  <= fresh ? 3'd0 : aCnt;
      bCnt  <= fresh ? 2'd1 : bCnt + 2'd1;
      opB   <= (fresh | (bCnt == 2'd0)) ? {8'h00, bus.wdata} : {bus.wdata, opB[7:0]};
      state <= masq_pkg::S_LOAD;
    end else begin
      case (state)
        masq_pkg::S_BUSY: begin
          lat <= lat - 6'd1;
          if (lat == 6'd0) begin
            state <= masq_pkg::S_READ;
          end
        end
        masq_pkg::S_READ: begin
          if (rdA & readOkA) begin
            aLeft <= aLeft - 3'd1;
          end
          if (rdB & readOkB) begin
            bLeft <= bLeft - 2'd1;
          end
          if (lastRead) begin
            state <= masq_pkg::S_IDLE;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read data and busy flag
  // ****************************************************************
  assign busy = (state == masq_pkg::S_BUSY) | inErr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rdata <= 8'h00;
    end else if (rdA & readOkA & ~badRdR) begin
      bus.rdata <= aByte;
    end else if (rdB & readOkB & ~badRdR) begin
      bus.rdata <= bByte;
    end else if (rdS) begin
      bus.rdata <= {busy, 7'h00};
    end else if (rdC) begin
      bus.rdata <= ctrlReg;
    end else if (bus.acc & ~bus.wr) begin
      bus.rdata <= 8'h00;
    end
  end
endmodule : masq_device

//--- logic/masq_defs.svh
// Constants for the math accelerator sequencer
// Overview of operation
// - Dividend bytes go to operand A, low first
// - Divisor low then high to B starts divide
// - Divide done, busy cleared within nine cycles
// - Quotient read from A, MSB first
// - Remainder read from B, high then low
// - Multiply: B low, high, then A low, high
// - Multiply done within six machine cycles
// - Product read from A, top byte first
// - Shift: four A bytes, then control launches
// - Shift done in nine cycles, MSB first
// - Normalize: four A bytes, control written zero
// - Normalize input must be nonzero
// - Normalize done in nine, mantissa MSB first
// - Operation chosen by access order; control value splits shift from normalize
// - Out-of-order access corrupts while loading or busy; clear busy restarts
// - Unrelated accesses between steps are ignored
`ifndef MASQ_DEFS_SVH
`define MASQ_DEFS_SVH

// ****************************************************************
// Port selects
// ****************************************************************
`define MASQ_SEL_OTHER 3'h0
`define MASQ_SEL_A     3'h1
`define MASQ_SEL_B     3'h2
`define MASQ_SEL_CTRL  3'h3
`define MASQ_SEL_STAT  3'h4

// ****************************************************************
// Fields
// ****************************************************************
`define MASQ_BUSY_BIT  7
`define MASQ_LEFT_BIT  7
`define MASQ_CNT_LSB   0
`define MASQ_CNT_MSB   4
`define MASQ_NORM_CODE 8'h00
`define MASQ_CTRL_RST  8'h00

// ****************************************************************
// Timing, one core clock per input clock period
// ****************************************************************
`define MASQ_CLKS_PER_MC 4
`define MASQ_DIV_MC      9
`define MASQ_MUL_MC      6
`define MASQ_SHIFT_MC    9
`define MASQ_DIV_CLKS    (`MASQ_DIV_MC * `MASQ_CLKS_PER_MC)
`define MASQ_MUL_CLKS    (`MASQ_MUL_MC * `MASQ_CLKS_PER_MC)
`define MASQ_SHIFT_CLKS  (`MASQ_SHIFT_MC * `MASQ_CLKS_PER_MC)

`endif

//--- logic/masq_pkg.sv
// Types for the math accelerator link; only masq_sel_t is shared by both ends
package masq_pkg;
  typedef logic [2:0] masq_sel_t;
  typedef enum logic [2:0] {OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM} masq_op_e;
  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_BUSY, S_READ, S_ERROR} masq_state_e;
  typedef enum logic [2:0] {H_IDLE, H_CLR, H_WR, H_POLL, H_RD} masq_hstate_e;
endpackage : masq_pkg

//--- logic/masq_if.sv
// Register-port link between processor core and accelerator
`timescale 1ns/100ps
interface masq_if;
  logic                 acc;
  logic                 wr;
  masq_pkg::masq_sel_t  sel;
  logic [7:0]           wdata;
  logic [7:0]           rdata;

  modport dev  (input acc, input wr, input sel, input wdata, output rdata);
  modport host (output acc, output wr, output sel, output wdata, input rdata);
endinterface : masq_if

//--- logic/masq_host.sv
// Core end: drives operand port sequences and collects results
`timescale 1ns/100ps
`include "masq_defs.svh"
module masq_host (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  masq_if.host                    bus,
  input  wire logic               cmdValid,
  input  wire masq_pkg::masq_op_e cmdOp,
  input  wire logic [31:0]        cmdA,
  input  wire logic [15:0]        cmdB,
  input  wire logic [7:0]         cmdCtrl,
  input  wire logic               clrReq,
  output logic                    cmdReady,
  output logic                    resValid,
  output logic [31:0]             resMain,
  output logic [15:0]             resRem
);
  masq_pkg::masq_hstate_e state;
  masq_pkg::masq_op_e     op;
  logic [31:0] a;
  logic [15:0] b;
  logic [7:0]  ctrl;
  logic [2:0]  step;
  logic        pend;
  logic        pendB;

  // ****************************************************************
  // Write sequence per operation
  // ****************************************************************
  logic [2:0]          nWr;
  masq_pkg::masq_sel_t wSel;
  logic [7:0]          wData;
  always_comb begin
    nWr   = 3'd5;
    wSel  = `MASQ_SEL_A;
    wData = a[8 * step[1:0] +: 8];
    case (op)
      masq_pkg::OP_DIV32: begin
        nWr = 3'd6;
        if (step > 3'd3) begin
          wSel  = `MASQ_SEL_B;
          wData = step[0] ? b[15:8] : b[7:0];
        end
      end
      masq_pkg::OP_DIV16: begin
        nWr = 3'd4;
        if (step > 3'd1) begin
          wSel  = `MASQ_SEL_B;
          wData = step[0] ? b[15:8] : b[7:0];
        end
      end
      masq_pkg::OP_MUL: begin
        nWr   = 3'd4;
        wSel  = (step < 3'd2) ? `MASQ_SEL_B : `MASQ_SEL_A;
        wData = (step < 3'd2) ? (step[0] ? b[15:8] : b[7:0]) : (step[0] ? a[15:8] : a[7:0]);
      end
      masq_pkg::OP_SHIFT, masq_pkg::OP_NORM: begin
        if (step == 3'd4) begin
          wSel  = `MASQ_SEL_CTRL;
          wData = (op == masq_pkg::OP_NORM) ? `MASQ_NORM_CODE : ctrl;
        end
      end
      default: begin
        nWr = 3'd5;
      end
    endcase
  end

  wire       isDiv  = (op == masq_pkg::OP_DIV32) | (op == masq_pkg::OP_DIV16);
  wire       inWr   = (state == masq_pkg::H_WR);
  wire       inClr  = (state == masq_pkg::H_CLR);
  wire       inRd   = (state == masq_pkg::H_RD);
  wire [2:0] nA     = (op == masq_pkg::OP_DIV16) ? 3'd2 : 3'd4;
  wire [2:0] nRd    = isDiv ? nA + 3'd2 : nA;
  wire       rdIss  = inRd & (step < nRd);
  wire       poIss  = (state == masq_pkg::H_POLL) & ~pend;
  wire       rdSelB = step >= nA;

  assign cmdReady  = (state == masq_pkg::H_IDLE) & ~clrReq;
  assign bus.acc   = inWr | inClr | poIss | rdIss;
  assign bus.wr    = inWr | inClr;
  assign bus.sel   = inWr ? wSel : inRd ? (rdSelB ? `MASQ_SEL_B : `MASQ_SEL_A) : `MASQ_SEL_STAT;
  assign bus.wdata = inWr ? wData : 8'h00;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= masq_pkg::H_IDLE;
      op       <= masq_pkg::OP_DIV32;
      a        <= 32'h00000000;
      b        <= 16'h0000;
      ctrl     <= 8'h00;
      step     <= 3'd0;
      pend     <= 1'b0;
      pendB    <= 1'b0;
      resValid <= 1'b0;
      resMain  <= 32'h00000000;
      resRem   <= 16'h0000;
    end else begin
      resValid <= 1'b0;
      case (state)
        masq_pkg::H_IDLE: begin
          step <= 3'd0;
          pend <= 1'b0;
          if (clrReq) begin
            state <= masq_pkg::H_CLR;
          end else if (cmdValid) begin
            op      <= cmdOp;
            a       <= cmdA;
            b       <= cmdB;
            ctrl    <= cmdCtrl;
            resMain <= 32'h00000000;
            resRem  <= 16'h0000;
            state   <= masq_pkg::H_WR;
          end
        end
        masq_pkg::H_CLR: begin
          state <= masq_pkg::H_IDLE;
        end
        masq_pkg::H_WR: begin
          step <= step + 3'd1;
          if (step == nWr - 3'd1) begin
            step  <= 3'd0;
            state <= masq_pkg::H_POLL;
          end
        end
        masq_pkg::H_POLL: begin
          pend <= ~pend;
          if (pend & ~bus.rdata[`MASQ_BUSY_BIT]) begin
            pend  <= 1'b0;
            state <= masq_pkg::H_RD;
          end
        end
        masq_pkg::H_RD: begin
          pend  <= rdIss;
          pendB <= rdSelB;
          if (rdIss) begin
            step <= step + 3'd1;
          end
          if (pend & ~pendB) begin
            resMain <= {resMain[23:0], bus.rdata};
          end
          if (pend & pendB) begin
            resRem <= {resRem[7:0], bus.rdata};
          end
          if (pend & ~rdIss) begin
            resValid <= 1'b1;
            state    <= masq_pkg::H_IDLE;
          end
        end
        default: begin
          state <= masq_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule : masq_host

//--- test/masq_monitor.sv
// Checker for the register-port link of the math accelerator
`timescale 1ns/100ps
`include "masq_defs.svh"
module masq_monitor #(
  parameter int DIV_CLKS   = 36,
  parameter int MUL_CLKS   = 24,
  parameter int SHIFT_CLKS = 36
) (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                acc,
  input wire logic                wr,
  input wire masq_pkg::masq_sel_t sel,
  input wire logic [7:0]          wdata,
  input wire logic [7:0]          rdata,
  input wire logic                busy,
  input wire logic                seqError
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  localparam int MAXA = (DIV_CLKS > SHIFT_CLKS) ? DIV_CLKS : SHIFT_CLKS;
  localparam int MAXL = (MAXA > MUL_CLKS) ? MAXA : MUL_CLKS;
  logic [15:0] busyRun;
  wire         rdReq = acc && !wr;
  wire         wrReq = acc && wr;
  wire         abSel = (sel == `MASQ_SEL_A) || (sel == `MASQ_SEL_B);
  wire         stSel = sel == `MASQ_SEL_STAT;
  // Error busy is unbounded by design, so it clears the count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyRun <= 16'h0;
    end else if (busy && !seqError) begin
      busyRun <= busyRun + 16'h1;
    end else begin
      busyRun <= 16'h0;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_holds_idle: assert property (!rdReq |=> $stable(rdata))
    else $error("rdata moved without a read");
  a_status_shows_busy: assert property (rdReq && stSel |=> rdata[7] == $past(busy))
    else $error("status bit7 differs from busy");
  a_ctrl_launches: assert property (wrReq && sel == `MASQ_SEL_CTRL && !busy |=> busy)
    else $error("control write did not set busy");
  a_busy_bounded: assert property (busyRun <= MAXL)
    else $error("busy held too long");
  a_error_keeps_busy: assert property (seqError |-> busy)
    else $error("error without busy");
  a_clear_restarts: assert property (wrReq && stSel && wdata == 8'h00 |=> !busy && !seqError)
    else $error("clear did not restart");
  a_busy_has_cause: assert property ($rose(busy) |-> $past(acc && sel != `MASQ_SEL_OTHER))
    else $error("busy rose with no access");
  a_poll_only_status: assert property (busy && acc |-> !abSel && sel != `MASQ_SEL_CTRL)
    else $error("operand access while busy");
  a_read_no_launch: assert property (rdReq && abSel && !busy |=> !busy)
    else $error("read set busy");
  c_launch: cover property ($rose(busy));
  c_ctrl_write: cover property (wrReq && sel == `MASQ_SEL_CTRL);
  c_remainder_read: cover property (rdReq && sel == `MASQ_SEL_B);
endmodule : masq_monitor

//--- test/math_accelerator_sequencer_tb.sv
// Testbench joining host and accelerator, plus a directly driven accelerator
`timescale 1ns/100ps
`include "masq_defs.svh"
module math_accelerator_sequencer_tb;
  localparam int DIVC = 6;
  localparam int MULC = 5;
  localparam int SHC  = 7;
  logic                core_clk = 1'b0;
  logic                rst_n    = 1'b0;
  logic                cmdValid = 1'b0;
  masq_pkg::masq_op_e  cmdOp    = masq_pkg::OP_DIV32;
  logic [31:0]         cmdA     = 32'h0;
  logic [15:0]         cmdB     = 16'h0;
  logic [7:0]          cmdCtrl  = 8'h0;
  logic                clrReq   = 1'b0;
  logic                cmdReady, resValid, busy, seqError, busyE, seqErrorE;
  logic [31:0]         resMain;
  logic [15:0]         resRem;
  logic                rdPend   = 1'b0;
  masq_pkg::masq_sel_t rdSel    = 3'h0;
  logic [10:0]         wq[$];
  logic [10:0]         rq[$];
  int                  n_fail   = 0;
  int                  cmp_count = 0;
  masq_if ifc0 ();
  masq_if ifc1 ();
  masq_host i_masq_host (.core_clk(core_clk), .rst_n(rst_n), .bus(ifc0), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdA(cmdA), .cmdB(cmdB), .cmdCtrl(cmdCtrl), .clrReq(clrReq),
    .cmdReady(cmdReady), .resValid(resValid), .resMain(resMain), .resRem(resRem));
  masq_device #(.DIV_CLKS(DIVC), .MUL_CLKS(MULC), .SHIFT_CLKS(SHC)) i_masq_device (
    .core_clk(core_clk), .rst_n(rst_n), .bus(ifc0), .busy(busy), .seqError(seqError));
  masq_device #(.DIV_CLKS(DIVC), .MUL_CLKS(MULC), .SHIFT_CLKS(SHC)) i_masq_device_err (
    .core_clk(core_clk), .rst_n(rst_n), .bus(ifc1), .busy(busyE), .seqError(seqErrorE));
  masq_monitor #(.DIV_CLKS(DIVC), .MUL_CLKS(MULC), .SHIFT_CLKS(SHC)) i_masq_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .acc(ifc0.acc), .wr(ifc0.wr), .sel(ifc0.sel),
    .wdata(ifc0.wdata), .rdata(ifc0.rdata), .busy(busy), .seqError(seqError));
  always #2 core_clk = ~core_clk;
  // ****************************************************************
  // Wire log: writes at the taking edge, read answers a half cycle later
  // ****************************************************************
  always @(posedge core_clk) begin
    rdPend <= ifc0.acc && !ifc0.wr && (ifc0.sel inside {`MASQ_SEL_A, `MASQ_SEL_B});
    rdSel <= ifc0.sel;
    if (ifc0.acc && ifc0.wr && (ifc0.sel inside {`MASQ_SEL_A, `MASQ_SEL_B, `MASQ_SEL_CTRL}))
      wq.push_back({ifc0.sel, ifc0.wdata});
  end
  always @(negedge core_clk) begin
    if (rdPend) rq.push_back({rdSel, ifc0.rdata});
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task end_of_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic run(input masq_pkg::masq_op_e op, input logic [31:0] a, input logic [15:0] b,
           input logic [7:0] c);
    logic [31:0] em, dv;
    logic [15:0] rem;
    logic [10:0] ew[$];
    logic [10:0] er[$];
    logic        isDiv;
    int          i;
    isDiv = op inside {masq_pkg::OP_DIV32, masq_pkg::OP_DIV16};
    dv = (op == masq_pkg::OP_DIV16) ? {16'h0, a[15:0]} : a;
    rem = (b == 16'h0) ? dv[15:0] : 16'(dv % b);
    case (op)
      masq_pkg::OP_DIV32, masq_pkg::OP_DIV16: em = (b == 16'h0) ? 32'hffffffff : dv / b;
      masq_pkg::OP_MUL: em = {16'h0, a[15:0]} * {16'h0, b};
      masq_pkg::OP_SHIFT: em = c[7] ? a << c[4:0] : a >> c[4:0];
      default: begin
        em = a;
        while (em[31] !== 1'b1) em = em << 1;
      end
    endcase
    if (op == masq_pkg::OP_MUL) begin
      ew.push_back({`MASQ_SEL_B, b[7:0]});
      ew.push_back({`MASQ_SEL_B, b[15:8]});
    end
    for (i = 0; i < ((op inside {masq_pkg::OP_DIV16, masq_pkg::OP_MUL}) ? 2 : 4); i++)
      ew.push_back({`MASQ_SEL_A, a[8*i+:8]});
    if (isDiv) begin
      ew.push_back({`MASQ_SEL_B, b[7:0]});
      ew.push_back({`MASQ_SEL_B, b[15:8]});
    end
    if (op == masq_pkg::OP_SHIFT) ew.push_back({`MASQ_SEL_CTRL, c});
    if (op == masq_pkg::OP_NORM) ew.push_back({`MASQ_SEL_CTRL, `MASQ_NORM_CODE});
    for (i = (op == masq_pkg::OP_DIV16) ? 1 : 3; i >= 0; i--) er.push_back({`MASQ_SEL_A, em[8*i+:8]});
    if (isDiv) begin
      er.push_back({`MASQ_SEL_B, rem[15:8]});
      er.push_back({`MASQ_SEL_B, rem[7:0]});
    end
    wq.delete();
    rq.delete();
    i = 0;
    @(negedge core_clk);
    while (cmdReady !== 1'b1) begin
      @(negedge core_clk);
      i++;
      if (i > 100) begin
        chk(1'b0, "ready timeout");
        end_of_test();
      end
    end
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdA <= a;
    cmdB <= b;
    cmdCtrl <= c;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    i = 0;
    while (resValid !== 1'b1) begin
      @(negedge core_clk);
      i++;
      if (i > 400) begin
        chk(1'b0, "result timeout");
        end_of_test();
      end
    end
    chk(resMain === em, "main result");
    if (isDiv) chk(resRem === rem, "remainder");
    chk(wq.size() == ew.size(), "write count");
    foreach (ew[k]) chk(wq[k] === ew[k], "write byte");
    chk(rq.size() == er.size(), "read count");
    foreach (er[k]) chk(rq[k] === er[k], "read byte");
  endtask : run
  task a1(input logic w, input masq_pkg::masq_sel_t s, input logic [7:0] d);
    @(posedge core_clk);
    ifc1.acc <= 1'b1;
    ifc1.wr <= w;
    ifc1.sel <= s;
    ifc1.wdata <= d;
  endtask : a1
  task idle1();
    @(posedge core_clk);
    ifc1.acc <= 1'b0;
    @(negedge core_clk);
  endtask : idle1
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] p;
    int          n;
    ifc1.acc = 1'b0;
    ifc1.wr = 1'b0;
    ifc1.sel = 3'h0;
    ifc1.wdata = 8'h0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    run(masq_pkg::OP_DIV32, 32'h12345678, 16'h1234, 8'h00);
    run(masq_pkg::OP_DIV16, 32'ha5a5beef, 16'h0013, 8'h00);
    run(masq_pkg::OP_DIV32, 32'hdeadbeef, 16'h0000, 8'h00);
    run(masq_pkg::OP_MUL, 32'h5a5afedc, 16'hba98, 8'h00);
    run(masq_pkg::OP_SHIFT, 32'h80000001, 16'h0000, 8'h85);
    run(masq_pkg::OP_SHIFT, 32'h80000001, 16'h0000, 8'h1f);
    run(masq_pkg::OP_SHIFT, 32'hc3c3a5a5, 16'h0000, 8'h80);
    run(masq_pkg::OP_NORM, 32'h00000001, 16'h0000, 8'h00);
    run(masq_pkg::OP_NORM, 32'h80000000, 16'h0000, 8'h00);
    @(posedge core_clk);
    clrReq <= 1'b1;
    @(negedge core_clk);
    chk(cmdReady === 1'b0, "ready during clear");
    @(posedge core_clk);
    clrReq <= 1'b0;
    a1(1'b0, `MASQ_SEL_A, 8'h00);
    idle1();
    chk(ifc1.rdata === 8'h00 && seqErrorE === 1'b0, "idle read");
    a1(1'b1, `MASQ_SEL_A, 8'h11);
    a1(1'b0, `MASQ_SEL_B, 8'h00);
    idle1();
    chk(seqErrorE === 1'b1 && busyE === 1'b1, "out of order");
    a1(1'b1, `MASQ_SEL_STAT, 8'h80);
    idle1();
    chk(seqErrorE === 1'b1, "status bit7 write");
    a1(1'b1, `MASQ_SEL_STAT, 8'h00);
    idle1();
    chk(busyE === 1'b0 && seqErrorE === 1'b0, "clear");
    // Unrelated accesses between every operand step must not disturb the multiply
    a1(1'b1, `MASQ_SEL_B, 8'hcd);
    a1(1'b1, `MASQ_SEL_OTHER, 8'hff);
    a1(1'b1, `MASQ_SEL_B, 8'hab);
    a1(1'b0, `MASQ_SEL_OTHER, 8'h00);
    a1(1'b1, `MASQ_SEL_A, 8'h34);
    a1(1'b1, `MASQ_SEL_OTHER, 8'h00);
    a1(1'b1, `MASQ_SEL_A, 8'h12);
    idle1();
    p = 32'h00001234 * 32'h0000abcd;
    n = 0;
    while (busyE === 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk(n == MULC, "multiply busy length");
    for (int i = 3; i >= 0; i--) begin
      a1(1'b0, `MASQ_SEL_OTHER, 8'h00);
      a1(1'b0, `MASQ_SEL_A, 8'h00);
      a1(1'b1, `MASQ_SEL_OTHER, 8'hff);
      @(negedge core_clk);
      chk(ifc1.rdata === p[8*i+:8], "product byte");
    end
    idle1();
    chk(busyE === 1'b0 && seqErrorE === 1'b0, "readout end");
    end_of_test();
  end
endmodule : math_accelerator_sequencer_tb
